// ==== rtl/srseq_top.v ====
/*
  system reset sequencer: gathers reset requests, holds the device in
  reset, runs the release phases and records the reset cause.
  assumes requests and the 1 kHz clock are asynchronous pins, the
  sleep/programming/protection inputs come from logic on clk_sys, and
  software reaches the registers over axi4-lite.
*/
// The AXI4-Lite register port was decided locally.
`include "srseq_consts.vh"

module srseq_top #(
  parameter ADDR_W = 8
) (
  input  wire              clk_sys,
  input  wire              rst,
  input  wire              por_req,
  input  wire              pin_rst_n,
  input  wire              wdt_timeout,
  input  wire              dbg_reset_req,
  input  wire              uv_below,
  input  wire              low_power_1k_osc,
  input  wire              osc_ready,
  input  wire [1:0]        release_delay_code,
  input  wire [2:0]        undervoltage_threshold_sel,
  input  wire [1:0]        undervoltage_mode_active,
  input  wire [1:0]        undervoltage_mode_sleep,
  input  wire              deep_sleep,
  input  wire              prog_mode,
  input  wire              chip_erase,
  input  wire              debug_port_en,
  input  wire              ccp_unlock,
  output wire              sys_reset,
  output wire              clk_sel_internal,
  output reg               osc_enable,
  output reg               cal_load,
  output reg               uv_power,
  output reg  [2:0]        uv_level,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready
);

  localparam integer WDT_CYC = `SRSEQ_WDT_CYC;
  localparam integer UV_FILT = `SRSEQ_UV_FILT_CYC;
  localparam integer UV_WIN  = UV_FILT + 2;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [6:0] ulp_count;
    input [1:0] code;
    ulp_count = (code == `SRSEQ_SUT_SHORT) ? `SRSEQ_ULP_SHORT : `SRSEQ_ULP_LONG;  // reserved 10 as 00
  endfunction

  function [6:0] reg_idx;
    input [ADDR_W-1:0] a;
    reg_idx = (a[1:0] != 2'h0 || (a >> 2) > 6'h3f) ? 7'h7f : {1'b0, a[7:2]};
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [6:0] pin_raw = {osc_ready, low_power_1k_osc, uv_below, dbg_reset_req,
                        wdt_timeout, ~pin_rst_n, por_req};
  reg  [6:0] pin_s1;
  reg  [6:0] pin_s2;
  reg        lp_prev;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1  <= 7'h00;
      pin_s2  <= 7'h00;
      lp_prev <= 1'b0;
    end else begin
      pin_s1  <= pin_raw;
      pin_s2  <= pin_s1;
      lp_prev <= pin_s2[5];
    end
  end

  wire por_s  = pin_s2[0];
  wire pin_s  = pin_s2[1];
  wire wdt_s  = pin_s2[2];
  wire dbg_s  = pin_s2[3];  // only the debug port drives this input
  wire uv_s   = pin_s2[4];
  wire lp_s   = pin_s2[5];
  wire osc_s  = pin_s2[6];
  wire lp_rise = lp_s & ~lp_prev;

  // ----------------------------------------
  // request catch: a glitch shorter than the synchroniser is not lost
  // ----------------------------------------
  wire raw_any   = por_req | ~pin_rst_n | dbg_reset_req | wdt_timeout;
  wire catch_set = raw_any | rst;
  reg  catch;
  reg  catch_s1;
  reg  catch_s2;

  always @(posedge clk_sys or posedge catch_set) begin
    if (catch_set)
      catch <= 1'b1;
    else if (catch_s2)
      catch <= 1'b0;
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      catch_s1 <= 1'b1;
      catch_s2 <= 1'b1;
    end else begin
      catch_s1 <= catch;
      catch_s2 <= catch_s1;
    end
  end

  // ----------------------------------------
  // watchdog request stretch
  // ----------------------------------------
  reg [7:0] wdt_cnt;
  wire      wdt_hold = (wdt_cnt != 8'h00);

  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      wdt_cnt <= 8'h00;
    else if (wdt_s)
      wdt_cnt <= WDT_CYC[7:0];  // 750 ns, between one and two 2 MHz periods
    else if (wdt_hold)
      wdt_cnt <= wdt_cnt - 8'h01;
  end

  // ----------------------------------------
  // undervoltage detector control
  // ----------------------------------------
  reg  [2:0] thr_sel;
  reg        uv_trip;
  reg        uv_latch_cont;
  reg  [8:0] uv_filt;
  reg  [8:0] uv_win;

  wire [1:0] uv_mode  = deep_sleep ? undervoltage_mode_sleep
                                   : undervoltage_mode_active;
  wire       mode_off = (uv_mode == `SRSEQ_UV_OFF) || (uv_mode == 2'h0);
  wire       forced   = mode_off & (chip_erase | debug_port_en);
  wire       mode_cont = (uv_mode == `SRSEQ_UV_CONT) | forced | uv_latch_cont;
  wire       mode_smp  = (uv_mode == `SRSEQ_UV_SAMPLED) & ~uv_latch_cont;
  wire       uv_on     = mode_cont | (mode_smp & (uv_win != 9'h000));

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      thr_sel       <= 3'h7;
      uv_level      <= 3'h0;
      uv_power      <= 1'b0;
      uv_filt       <= 9'h000;
      uv_win        <= 9'h000;
      uv_trip       <= 1'b0;
      uv_latch_cont <= 1'b0;
    end else begin
      if (!prog_mode)
        thr_sel <= undervoltage_threshold_sel;
      uv_level <= forced ? 3'h0 : ~thr_sel;
      if (mode_smp && lp_rise)
        uv_win <= UV_WIN[8:0];  // one sample per rising slow-clock edge
      else if (uv_win != 9'h000)
        uv_win <= uv_win - 9'h001;
      uv_power <= uv_on;  // off between samples
      if (uv_on && uv_s && !uv_trip) begin
        if (uv_filt == UV_FILT[8:0] - 9'h001) begin
          uv_trip <= 1'b1;
          if (mode_smp)
            uv_latch_cont <= 1'b1;
        end
        uv_filt <= uv_filt + 9'h001;
      end else begin
        uv_filt <= 9'h000;
      end
      if (!uv_s) begin
        uv_trip       <= 1'b0;  // release then goes through the delay
        uv_latch_cont <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // release sequencer
  // ----------------------------------------
  localparam [2:0] S_HOLD = `SRSEQ_S_HOLD;
  localparam [2:0] S_ULP  = `SRSEQ_S_ULP;
  localparam [2:0] S_SYS  = `SRSEQ_S_SYS;
  localparam [2:0] S_OSC  = `SRSEQ_S_OSC;
  localparam [2:0] S_CAL  = `SRSEQ_S_CAL;
  localparam [2:0] S_RUN  = `SRSEQ_S_RUN;

  reg  [2:0] state;
  reg  [6:0] cnt;
  reg        sw_req;
  wire       req_any = catch_s2 | por_s | pin_s | dbg_s | wdt_hold
                     | uv_trip | sw_req;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state      <= S_HOLD;
      cnt        <= 7'h00;
      osc_enable <= 1'b0;
      cal_load   <= 1'b0;
    end else begin
      cal_load <= 1'b0;
      if (req_any) begin
        state      <= S_HOLD;
        cnt        <= 7'h00;
        osc_enable <= 1'b0;
      end else begin
        case (state)
          S_HOLD: begin
            cnt   <= 7'h00;
            state <= (release_delay_code == `SRSEQ_SUT_NONE) ? S_SYS : S_ULP;
          end
          S_ULP: begin
            if (lp_rise) begin
              if (cnt == ulp_count(release_delay_code) - 7'h01) begin
                cnt   <= 7'h00;
                state <= S_SYS;
              end else begin
                cnt <= cnt + 7'h01;
              end
            end
          end
          S_SYS: begin
            if (cnt == {2'h0, `SRSEQ_SYS_TAIL} - 7'h01) begin
              state      <= S_OSC;
              osc_enable <= 1'b1;
            end
            cnt <= cnt + 7'h01;
          end
          S_OSC: begin
            if (osc_s) begin
              state    <= S_CAL;
              cal_load <= 1'b1;
            end
          end
          S_CAL: state <= S_RUN;
          S_RUN: state <= S_RUN;
          default: state <= S_HOLD;
        endcase
      end
    end
  end

  // raw pins force reset without a clock; release only follows the state
  assign sys_reset        = raw_any | catch | sw_req | (state != S_RUN);
  assign clk_sel_internal = sys_reset;

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  reg              aw_full;
  reg              w_full;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0]       w_data;
  reg [3:0]        w_strb;
  reg [5:0]        cause;

  assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full & ~s_axi_bvalid;

  wire       wr_go  = aw_full & w_full & ~s_axi_bvalid;
  wire [6:0] wr_idx = reg_idx(aw_addr);
  wire       wr_b0  = wr_go & w_strb[0];
  wire       wr_cause = wr_b0 & (wr_idx == {1'b0, `SRSEQ_IDX_CAUSE});
  wire       wr_ctrl  = wr_b0 & (wr_idx == {1'b0, `SRSEQ_IDX_CTRL});
  wire       wr_ok  = (wr_idx == {1'b0, `SRSEQ_IDX_CAUSE})
                    | (wr_idx == {1'b0, `SRSEQ_IDX_CTRL})
                    | (wr_idx == {1'b0, `SRSEQ_IDX_STATE});

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= {ADDR_W{1'b0}};
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // software reset bit and cause flags
  // ----------------------------------------
  wire [5:0] cause_set = {sw_req, dbg_s, wdt_hold, uv_trip, pin_s, por_s};
  wire [5:0] cause_clr = wr_cause ? w_data[5:0] : 6'h00;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sw_req <= 1'b0;
      cause  <= `SRSEQ_CAUSE_RST;
    end else begin
      // software reset writes only land with the protection window open; cause clears do not need it
      if (wr_ctrl && ccp_unlock && w_data[`SRSEQ_BIT_SWREQ])
        sw_req <= 1'b1;
      else if (state == S_HOLD)
        sw_req <= 1'b0;  // self-clears once reset is issued
      // power-on wipes the other flags; a coincident event still sets
      if (por_s)
        cause <= cause_set;
      else
        cause <= (cause & ~cause_clr) | cause_set;  // set wins over write-one clear
    end
  end

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  wire [6:0] rd_idx = reg_idx(s_axi_araddr);
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (rd_idx)
        {1'b0, `SRSEQ_IDX_CAUSE}: s_axi_rdata <= {26'h0000000, cause};
        {1'b0, `SRSEQ_IDX_CTRL}:  s_axi_rdata <= {31'h00000000, sw_req};
        {1'b0, `SRSEQ_IDX_STATE}: s_axi_rdata <= {24'h000000, uv_trip, uv_power,
                                                  uv_level, state};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== rtl/srseq_consts.vh ====
/*
  constants for the system reset sequencer: register indices, field
  positions, reset values, state codes and timing counts.
  assumes a 4 ns system clock and the 1 kHz low-power clock as a pin.
*/
`ifndef SRSEQ_CONSTS_VH
`define SRSEQ_CONSTS_VH

// ----------------------------------------
// register indices (byte address is 4 x index)
// ----------------------------------------
`define SRSEQ_IDX_CAUSE       6'h00
`define SRSEQ_IDX_CTRL        6'h01
`define SRSEQ_IDX_STATE       6'h02

// ----------------------------------------
// field positions
// ----------------------------------------
`define SRSEQ_BIT_POR         0
`define SRSEQ_BIT_PIN         1
`define SRSEQ_BIT_UV          2
`define SRSEQ_BIT_WDT         3
`define SRSEQ_BIT_DBG         4
`define SRSEQ_BIT_SW          5
`define SRSEQ_BIT_SWREQ       0
`define SRSEQ_CAUSE_RST       6'h00

// ----------------------------------------
// release delay codes and counts
// ----------------------------------------
`define SRSEQ_SUT_LONG        2'h0
`define SRSEQ_SUT_SHORT       2'h1
`define SRSEQ_SUT_NONE        2'h3
`define SRSEQ_ULP_LONG        7'h40
`define SRSEQ_ULP_SHORT       7'h04
`define SRSEQ_SYS_TAIL        5'h18

// ----------------------------------------
// undervoltage detector mode codes
// ----------------------------------------
`define SRSEQ_UV_SAMPLED      2'h1
`define SRSEQ_UV_CONT         2'h2
`define SRSEQ_UV_OFF          2'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define SRSEQ_CLK_NS          4
`define SRSEQ_WDT_HOLD_NS     750
`define SRSEQ_WDT_CYC         ((`SRSEQ_WDT_HOLD_NS) / (`SRSEQ_CLK_NS))
`define SRSEQ_UV_FILT_NS      1000
`define SRSEQ_UV_FILT_CYC     ((`SRSEQ_UV_FILT_NS + `SRSEQ_CLK_NS - 1) / (`SRSEQ_CLK_NS))

// ----------------------------------------
// sequencer states
// ----------------------------------------
`define SRSEQ_S_HOLD          3'h0
`define SRSEQ_S_ULP           3'h1
`define SRSEQ_S_SYS           3'h2
`define SRSEQ_S_OSC           3'h3
`define SRSEQ_S_CAL           3'h4
`define SRSEQ_S_RUN           3'h5

`endif

// ==== testbench/srseq_top_properties.sv ====
/*
  port checker for the reset sequencer.
  assumes mode and threshold inputs change rarely.
*/
module srseq_chk (
  input wire       clk_sys,
  input wire       rst,
  input wire       por_req,
  input wire       pin_rst_n,
  input wire       dbg_reset_req,
  input wire       uv_below,
  input wire [2:0] undervoltage_threshold_sel,
  input wire [1:0] undervoltage_mode_active,
  input wire [1:0] undervoltage_mode_sleep,
  input wire       deep_sleep,
  input wire       prog_mode,
  input wire       chip_erase,
  input wire       debug_port_en,
  input wire       sys_reset,
  input wire       clk_sel_internal,
  input wire       osc_enable,
  input wire       cal_load,
  input wire       uv_power,
  input wire [2:0] uv_level
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire [1:0] md  = deep_sleep ? undervoltage_mode_sleep : undervoltage_mode_active;
  wire       frc = chip_erase | debug_port_en;
  wire       req = por_req | ~pin_rst_n | dbg_reset_req;
  // -------------------------------
  // low-supply run length in continuous mode, saturating
  // -------------------------------
  reg [8:0] uvc;
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      uvc <= 9'h000;
    else if (uv_below && md == 2'h2)
      uvc <= uvc + {8'h00, uvc != 9'h1ff};
    else
      uvc <= 9'h000;
  end
  a_req_holds_reset: assert property (req |-> sys_reset) else $error("request without reset");
  a_clk_sel_reset: assert property (clk_sel_internal == sys_reset) else $error("clock select off");
  a_req_stops_osc: assert property (req [*4] |-> !osc_enable) else $error("osc on in request");
  a_cal_single: assert property (cal_load |=> !cal_load) else $error("cal load too long");
  a_cal_after_osc: assert property (cal_load |-> osc_enable && sys_reset) else $error("cal out of order");
  a_release_clean: assert property ($fell(sys_reset) |-> osc_enable && !req && !$past(req, 2))
    else $error("bad release");
  a_uv_trip_reset: assert property (uvc > 9'd260 |-> sys_reset) else $error("low supply missed");
  a_uv_off_mode: assert property ((md == 2'h3 && !frc && !uv_below) [*4] |-> !uv_power)
    else $error("detector on when off");
  a_uv_cont_on: assert property ((md == 2'h2 || frc) [*4] |-> uv_power) else $error("detector off");
  a_uv_forced_low: assert property ((frc && md == 2'h3) [*4] |-> uv_level == 3'h0)
    else $error("forced level wrong");
  a_level_inverse: assert property ((!prog_mode && !frc && $stable(undervoltage_threshold_sel)) [*4]
    |-> uv_level == ~undervoltage_threshold_sel) else $error("level decode wrong");
  a_level_frozen: assert property ((prog_mode && !frc) [*2] |-> $stable(uv_level))
    else $error("level moved in prog");
endmodule
bind srseq_top srseq_chk i_chk (.clk_sys(clk_sys), .rst(rst), .por_req(por_req), .pin_rst_n(pin_rst_n),
  .dbg_reset_req(dbg_reset_req), .uv_below(uv_below), .undervoltage_threshold_sel(undervoltage_threshold_sel),
  .undervoltage_mode_active(undervoltage_mode_active), .undervoltage_mode_sleep(undervoltage_mode_sleep),
  .deep_sleep(deep_sleep), .prog_mode(prog_mode), .chip_erase(chip_erase), .debug_port_en(debug_port_en),
  .sys_reset(sys_reset), .clk_sel_internal(clk_sel_internal), .osc_enable(osc_enable),
  .cal_load(cal_load), .uv_power(uv_power), .uv_level(uv_level));

// ==== testbench/srseq_far.sv ====
/*
  far side: slow clock, oscillator and reset pin.
  assumes the bench sets the slow half period and osc delay.
*/
module srseq_far (
  input  wire  clk_sys,
  input  wire  rst,
  input  wire  osc_enable,
  input  wire  pin_low,
  input  int   half,
  input  int   odly,
  output logic low_power_1k_osc,
  output logic osc_ready,
  output wire  pin_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int sc;
  int oc;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sc <= 0;
      oc <= 0;
      low_power_1k_osc <= 1'b0;
      osc_ready <= 1'b0;
    end else begin
      // slow clock runs free, unlike the oscillator
      if (sc >= half - 1) begin
        sc <= 0;
        low_power_1k_osc <= ~low_power_1k_osc;
      end else
        sc <= sc + 1;
      // ready drops with enable so a restart waits again
      if (!osc_enable) begin
        oc <= 0;
        osc_ready <= 1'b0;
      end else if (oc >= odly)
        osc_ready <= 1'b1;
      else
        oc <= oc + 1;
    end
  end
  assign pin_rst_n = ~pin_low; // pull-up when nobody drives low
endmodule

// ==== testbench/test_srseq_top.sv ====
/*
  self-checking bench for the reset sequencer.
  assumes srseq_top, its checker and the far-side model.
*/
module test_srseq_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst = 1, por_req = 1, pin_low = 0, wdt = 0, dbg = 0, uvb = 0;
  logic [1:0] rdc = 2'h3, uma = 2'h3, ums = 2'h3;
  logic [2:0] sel = 3'h7;
  logic deep = 0, prog = 0, erase = 0, dpe = 0, ccp = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd;
  logic [3:0] wstrb = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire sys_reset, osc_en, osc_ready, low1k, pin_rst_n, uvp, awready, wready, bvalid, arready, rvalid;
  wire [2:0] uvl;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  logic [1:0] rs;
  int half = 130, odly = 5, bad_count = 0, n_checks = 0, cyc = 0, n;
  srseq_top #(.ADDR_W(8)) i_dut (.clk_sys(clk_sys), .rst(rst), .por_req(por_req), .pin_rst_n(pin_rst_n),
    .wdt_timeout(wdt), .dbg_reset_req(dbg), .uv_below(uvb), .low_power_1k_osc(low1k), .osc_ready(osc_ready),
    .release_delay_code(rdc), .undervoltage_threshold_sel(sel), .undervoltage_mode_active(uma),
    .undervoltage_mode_sleep(ums), .deep_sleep(deep), .prog_mode(prog), .chip_erase(erase),
    .debug_port_en(dpe), .ccp_unlock(ccp), .sys_reset(sys_reset), .clk_sel_internal(), .osc_enable(osc_en),
    .cal_load(), .uv_power(uvp), .uv_level(uvl), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  srseq_far i_far (.clk_sys(clk_sys), .rst(rst), .osc_enable(osc_en), .pin_low(pin_low), .half(half),
    .odly(odly), .low_power_1k_osc(low1k), .osc_ready(osc_ready), .pin_rst_n(pin_rst_n));
  always #2 clk_sys = ~clk_sys;
  // -------------------------------
  // shared tasks
  // -------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      end_sim;
    end
  end
  task chk(input [31:0] s, input [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 0;
  endtask
  task rdr(input [7:0] a);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 0;
  endtask
  // cycles from last request release until the device runs
  task meas;
    n = 0;
    while (sys_reset !== 1'b0) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  function int lo(input [1:0] c);
    lo = (c == 2'h3 ? 0 : (c == 2'h1 ? 3 : 63) * 2 * half) + 24 + odly;
  endfunction
  task rel(input [1:0] c, input bit ab);
    rdc <= c;
    odly <= $urandom % 30 + 1;
    pin_low <= 1; // held well past the minimum pulse
    tick(20);
    pin_low <= 0;
    if (ab) begin
      tick(300);
      chk(sys_reset, 1);
      dbg <= 1;
      tick(5);
      dbg <= 0;
    end
    meas;
    chk(n >= lo(c) && n <= lo(c) + (c == 2'h3 ? 0 : 2 * half) + 20, 1);
  endtask
  initial begin
    n = $urandom(32'h1607);
    tick(6);
    rst <= 0;
    tick(10);
    por_req <= 0;
    meas;
    chk(n >= 24 + odly && n <= 44 + odly, 1);
    rdr(8'h00);
    chk(rd, 32'h1);
    rdr(8'h40);
    chk(rs, 2'h2);
    chk(rd, 32'h0);
    wr(8'h44, $urandom);
    chk(rs, 2'h2);
    wr(8'h00, 32'h1);
    chk(rs, 2'h0);
    rdr(8'h00);
    chk(rd, 32'h0);
    $display("reset and bus test done");
    rel(2'h1, 1);
    rel(2'h0, 0);
    rel(2'h2, 0);
    rel(2'h3, 0);
    rdr(8'h00);
    chk(rd, 32'h12);
    $display("release delay test done");
    dbg <= 1; // only the programmer side drives this
    tick(8);
    chk(sys_reset, 1);
    dbg <= 0;
    meas;
    wdt <= 1;
    tick(1);
    wdt <= 0;
    meas;
    chk(n >= 200 && n <= 294 + odly, 1);
    wr(8'h04, 32'h1);
    tick(2);
    chk(sys_reset, 0);
    ccp <= 1;
    wr(8'h04, 32'h1);
    chk(sys_reset, 1);
    ccp <= 0;
    meas;
    rdr(8'h04);
    chk(rd[0], 0);
    rdr(8'h00);
    chk(rd, 32'h3a);
    wr(8'h00, 32'h18);
    rdr(8'h00);
    chk(rd, 32'h22);
    por_req <= 1;
    tick(5);
    por_req <= 0;
    meas;
    rdr(8'h00);
    chk(rd, 32'h1);
    $display("reset source test done");
    uma <= 2'h2;
    for (int i = 0; i < 8; i++) begin
      sel <= i;
      tick(6);
      chk(uvl, 3'h7 - i[2:0]);
    end
    prog <= 1;
    tick(2);
    sel <= 3'h2;
    tick(6);
    chk(uvl, 3'h0);
    prog <= 0;
    tick(6);
    chk(uvl, 3'h5);
    for (int k = 0; k < 8; k++) begin
      deep <= k[0];
      dpe <= k[1] & ~k[0];
      erase <= k[1] & k[0];
      uma <= k[2] ? 2'h2 : 2'h3;
      ums <= k[2] ? 2'h0 : 2'h2;
      tick(8);
      chk(uvp, k[1] | (k[0] ? !k[2] : k[2]));
    end
    {deep, dpe, erase} <= 3'h0;
    $display("detector mode test done");
    half <= 400;
    uma <= 2'h1;
    @(posedge low1k);
    tick(20);
    chk(uvp, 1);
    tick(400);
    chk(uvp, 0);
    @(posedge low1k);
    tick(500);
    uvb <= 1;
    tick(900);
    chk({sys_reset, uvp}, 2'h3);
    uvb <= 0;
    meas;
    rdr(8'h00);
    chk(rd[2], 1);
    $display("sampled detector test done");
    uma <= 2'h2;
    tick(4);
    uvb <= 1;
    tick(200);
    chk(sys_reset, 0); // filter has not run out yet
    tick(100);
    chk(sys_reset, 1);
    uvb <= 0;
    meas;
    chk(n >= 24 + odly && n <= 44 + odly, 1);
    $display("continuous detector test done");
    end_sim;
  end
endmodule
